//--- hw/sss_defines.svh
// Functional notes
// - Scans start from periodic hardware scan tick
// - Tick during busy scan: stop, code 2942
// - Channels processed promptly in scan-list order
// - Samples held in FIFO until host reads
// - FIFO size at most 32768 bytes
// - Power-of-two size only; zero means default
// - Two bytes per sample; capacity bytes/2
// - Size change affects only later streams
// - Full FIFO: discard until emptied, then resume
// - Count discarded scans, report to host
// - Overflow too long: recovery-end error, stop
// - Timing pin edges mark scan and sample
// - First scan one period after enable
// - First scan start latches tick counter
// - 32-bit tick counter at half clock rate
// - Stop after burst count; zero means continuous
// - Wide channel: low half streamed, high latched
`ifndef SSS_DEFINES_SVH
`define SSS_DEFINES_SVH

`define SSS_ADDR_FIFO_SIZE  16'hfac
`define SSS_ADDR_BURST      16'hfb4
`define SSS_ADDR_FIRST_TS   16'hfba
`define SSS_ADDR_TICK_CNT   16'hf050

`define SSS_FIFO_BYTES_RST  32'h0000_0000
`define SSS_FIFO_BYTES_MIN  32'h0000_0002
`define SSS_FIFO_BYTES_MAX  32'h0000_8000
`define SSS_FIFO_BYTES_DEF  32'h0000_1000
`define SSS_BURST_RST       32'h0000_0000
`define SSS_SAMPLE_SHIFT    1
`define SSS_MEM_WORDS       16384
`define SSS_MEM_AW          14

`define SSS_ERR_NONE        16'h0000
`define SSS_ERR_OVERLAP     16'h0b7e
`define SSS_ERR_OVF_END     16'h0b7f

`define SSS_CLK_MHZ         100
`define SSS_OVF_TOL_US      100000
`define SSS_OVF_TOL_CYC     (`SSS_OVF_TOL_US * `SSS_CLK_MHZ)

`endif

//--- hw/sss_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "sss_defines.svh"
interface sss_fifo_if;
  logic                   we;
  logic [`SSS_MEM_AW-1:0] waddr;
  logic [15:0]            wdata;
  logic                   re;
  logic [`SSS_MEM_AW-1:0] raddr;
  logic [15:0]            rdata;
  modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
  modport mem  (input we, waddr, wdata, re, raddr, output rdata);
endinterface
`default_nettype wire

//--- hw/sss_fifo_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "sss_defines.svh"
module sss_fifo_mem (
  input wire logic clk_in,
  sss_fifo_if.mem  port
);
  import sss_pkg::*;
  logic [15:0] mem [`SSS_MEM_WORDS];
  logic [15:0] rdata_r;

  // No reset on the array: it maps onto block RAM
  always_ff @(posedge clk_in) begin
    if (port.we) begin
      mem[port.waddr] <= port.wdata;
    end
    if (port.re) begin
      rdata_r <= mem[port.raddr];
    end
  end
  assign port.rdata = rdata_r;
endmodule
`default_nettype wire

//--- hw/sss_pkg.sv
`include "sss_defines.svh"
package sss_pkg;
  typedef enum logic [2:0] {
    SSS_IDLE, SSS_SCAN_START, SSS_SAMPLE, SSS_SAMPLE_END, SSS_SCAN_END
  } sss_seq_t;

  typedef struct packed {
    logic [31:0] div;
    logic        tick;
    logic        ph;
    logic [31:0] cnt;
  } sss_tmr_t;

  typedef struct packed {
    sss_seq_t    st;
    logic        en;
    logic        ovl;
    logic        ovfe;
    logic [15:0] code;
    logic [31:0] size_reg;
    logic [31:0] burst;
    logic [31:0] ts;
    logic        first;
    logic [14:0] cap;
    logic [13:0] wp;
    logic [13:0] rp;
    logic [14:0] cnt;
    logic        disc;
    logic        sdrop;
    logic [31:0] dropped;
    logic [31:0] ovfc;
    logic [31:0] scans;
    logic [7:0]  ch;
    logic        pin;
    logic        req;
    logic [15:0] upper;
    logic [31:0] rdata;
    logic        rvalid;
    logic        fvalid;
  } sss_state_t;
endpackage

//--- hw/sss_scan_timer.sv
`timescale 1ns/1ps
`default_nettype none
module sss_scan_timer (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Scan pacing
  input  wire logic        run_in,
  input  wire logic [31:0] period_in,
  output logic             tick_out,
  // Free-running time base
  output logic [31:0]      tick_cnt_out
);
  import sss_pkg::*;
  sss_tmr_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    s_nxt.ph = ~s_r.ph;
    if (s_r.ph) begin
      s_nxt.cnt = s_r.cnt + 32'h0000_0001;
    end
    // Restarting the divider on enable puts the first tick a full period out
    if (!run_in) begin
      s_nxt.div = 32'h0000_0000;
    end else if (s_r.div + 32'h0000_0001 >= period_in) begin
      s_nxt.div = 32'h0000_0000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.div = s_r.div + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick_out = s_r.tick;
  assign tick_cnt_out = s_r.cnt;

  property p_half_rate;
    @(posedge clk_in) disable iff (!rst_n_in)
    (s_r.cnt != $past(s_r.cnt)) |=> (s_r.cnt == $past(s_r.cnt)) ##1 (s_r.cnt != $past(s_r.cnt));
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("tick counter not at half rate");

  property p_wrap;
    @(posedge clk_in) disable iff (!rst_n_in)
    (s_r.cnt == 32'hffff_ffff && s_r.ph) |=> (s_r.cnt == 32'h0000_0000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("tick counter did not wrap");

  property p_spacing;
    @(posedge clk_in) disable iff (!rst_n_in)
    (tick_out && run_in && period_in > 32'h0000_0001) |=> !tick_out;
  endproperty
  a_spacing: assert property (p_spacing) else $error("scan ticks too close");
endmodule
`default_nettype wire

//--- hw/sss_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sss_defines.svh"
module sss_top #(
  parameter int unsigned OVF_TOL_CYC = `SSS_OVF_TOL_CYC
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // Register port
  input  wire logic [15:0] reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  output logic             reg_rvalid_out,
  // Stream control
  input  wire logic        acq_enable_set_in,
  input  wire logic        acq_enable_clr_in,
  input  wire logic [31:0] scan_period_in,
  input  wire logic [7:0]  scan_list_len_in,
  output logic             acquisition_enable_out,
  output logic             scan_overlap_error_out,
  output logic             overflow_end_error_out,
  output logic [15:0]      error_code_out,
  output logic [31:0]      discarded_scans_out,
  // Channel sampling
  output logic             sample_req_out,
  output logic [7:0]       sample_ch_out,
  input  wire logic        sample_ack_in,
  input  wire logic [31:0] sample_data_in,
  input  wire logic        sample_wide_in,
  output logic [15:0]      upper_half_capture_out,
  output logic             scan_timing_pulse_pin_out,
  // Host drain
  input  wire logic        fifo_rd_req_in,
  output logic [15:0]      fifo_rd_data_out,
  output logic             fifo_rd_valid_out
);
  import sss_pkg::*;

  logic [1:0]  rst_sync_r;
  logic        rst_n;
  logic        tick;
  logic [31:0] tick_cnt;
  sss_state_t  s_r, s_nxt;
  logic        push;
  logic        pop;
  logic        size_ok;
  logic [7:0]  last_ch;

  sss_fifo_if fif ();

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  sss_scan_timer u_timer (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n),
    .run_in       (s_r.en),
    .period_in    (scan_period_in),
    .tick_out     (tick),
    .tick_cnt_out (tick_cnt)
  );

  sss_fifo_mem u_mem (
    .clk_in (clk_in),
    .port   (fif.mem)
  );

  // Nonzero sizes above the ceiling, below one sample, or not a power of two are refused
  assign size_ok = (reg_wdata_in == `SSS_FIFO_BYTES_RST) ||
                   (reg_wdata_in >= `SSS_FIFO_BYTES_MIN &&
                    reg_wdata_in <= `SSS_FIFO_BYTES_MAX &&
                    (reg_wdata_in & (reg_wdata_in - 32'h0000_0001)) == 32'h0000_0000);
  assign last_ch = (scan_list_len_in == 8'h00) ? 8'h00 : scan_list_len_in - 8'h01;

  always_comb begin
    s_nxt = s_r;
    push = 1'b0;
    pop = 1'b0;
    s_nxt.rvalid = 1'b0;
    s_nxt.fvalid = 1'b0;

    // Register writes; the live capacity is not touched here
    if (reg_wr_in) begin
      if (reg_addr_in == `SSS_ADDR_FIFO_SIZE && size_ok) begin
        s_nxt.size_reg = reg_wdata_in;
      end
      if (reg_addr_in == `SSS_ADDR_BURST) begin
        s_nxt.burst = reg_wdata_in;
      end
    end
    if (reg_rd_in) begin
      s_nxt.rvalid = 1'b1;
      unique case (reg_addr_in)
        `SSS_ADDR_FIFO_SIZE: s_nxt.rdata = s_r.size_reg;
        `SSS_ADDR_BURST:     s_nxt.rdata = s_r.burst;
        `SSS_ADDR_FIRST_TS:  s_nxt.rdata = s_r.ts;
        `SSS_ADDR_TICK_CNT:  s_nxt.rdata = tick_cnt;
        default:             s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Host drain; reads of an empty buffer are ignored
    if (fifo_rd_req_in && s_r.cnt != 15'h0000) begin
      pop = 1'b1;
      s_nxt.rp = s_r.rp + 14'h0001;
      s_nxt.fvalid = 1'b1;
    end

    // Stream start: capacity fixed here for the whole session
    if (acq_enable_set_in && !s_r.en) begin
      s_nxt.en = 1'b1;
      s_nxt.ovl = 1'b0;
      s_nxt.ovfe = 1'b0;
      s_nxt.code = `SSS_ERR_NONE;
      s_nxt.first = 1'b0;
      s_nxt.scans = 32'h0000_0000;
      s_nxt.dropped = 32'h0000_0000;
      s_nxt.ovfc = 32'h0000_0000;
      s_nxt.disc = 1'b0;
      if (s_r.size_reg == `SSS_FIFO_BYTES_RST) begin
        s_nxt.cap = 15'(`SSS_FIFO_BYTES_DEF >> `SSS_SAMPLE_SHIFT);
      end else begin
        s_nxt.cap = 15'(s_r.size_reg >> `SSS_SAMPLE_SHIFT);
      end
    end else if (acq_enable_clr_in) begin
      s_nxt.en = 1'b0;
    end

    unique case (s_r.st)
      SSS_IDLE: begin
        if (tick && s_r.en) begin
          s_nxt.st = SSS_SCAN_START;
          s_nxt.pin = 1'b0;
          s_nxt.ch = 8'h00;
          s_nxt.sdrop = 1'b0;
          if (!s_r.first) begin
            s_nxt.first = 1'b1;
            s_nxt.ts = tick_cnt;
          end
        end
      end
      SSS_SCAN_START: begin
        s_nxt.st = SSS_SAMPLE;
        s_nxt.pin = 1'b1;
        s_nxt.req = 1'b1;
      end
      SSS_SAMPLE: begin
        if (sample_ack_in) begin
          s_nxt.req = 1'b0;
          s_nxt.pin = 1'b0;
          s_nxt.st = SSS_SAMPLE_END;
          if (sample_wide_in) begin
            s_nxt.upper = sample_data_in[31:16];
          end
          if (s_r.disc || s_r.cnt == s_r.cap) begin
            s_nxt.disc = 1'b1;
            s_nxt.sdrop = 1'b1;
          end else begin
            push = 1'b1;
            s_nxt.wp = s_r.wp + 14'h0001;
          end
        end
      end
      SSS_SAMPLE_END: begin
        if (s_r.ch == last_ch) begin
          s_nxt.st = SSS_SCAN_END;
          s_nxt.pin = 1'b1;
        end else begin
          s_nxt.ch = s_r.ch + 8'h01;
          s_nxt.st = SSS_SAMPLE;
          s_nxt.pin = 1'b1;
          s_nxt.req = 1'b1;
        end
      end
      SSS_SCAN_END: begin
        s_nxt.st = SSS_IDLE;
        s_nxt.scans = s_r.scans + 32'h0000_0001;
        if (s_r.sdrop) begin
          s_nxt.dropped = s_r.dropped + 32'h0000_0001;
        end
        if (s_r.burst != 32'h0000_0000 && s_r.scans + 32'h0000_0001 == s_r.burst) begin
          s_nxt.en = 1'b0;
        end
      end
    endcase

    // A tick that finds a scan still running is an overlap
    if (tick && s_r.en && s_r.st != SSS_IDLE) begin
      s_nxt.en = 1'b0;
      s_nxt.ovl = 1'b1;
      s_nxt.code = `SSS_ERR_OVERLAP;
    end

    // Discard ends only once the host has emptied the buffer; a stale discard
    // from a stopped session must neither cancel a new start nor overwrite its code
    if (s_r.disc && s_nxt.disc) begin
      if (s_r.cnt == 15'h0000 && !push) begin
        s_nxt.disc = 1'b0;
        s_nxt.ovfc = 32'h0000_0000;
      end else if (s_nxt.en) begin
        if (s_r.ovfc + 32'h0000_0001 >= OVF_TOL_CYC) begin
          s_nxt.en = 1'b0;
          s_nxt.ovfe = 1'b1;
          s_nxt.code = `SSS_ERR_OVF_END;
        end else begin
          s_nxt.ovfc = s_r.ovfc + 32'h0000_0001;
        end
      end
    end

    s_nxt.cnt = s_r.cnt + {14'h0000, push} - {14'h0000, pop};

    // Dropping enable aborts the scan and parks the pin high
    if (!s_nxt.en && !(s_r.st == SSS_SCAN_END)) begin
      s_nxt.st = SSS_IDLE;
      s_nxt.req = 1'b0;
      s_nxt.pin = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.st <= SSS_IDLE;
      s_r.pin <= 1'b1;
      s_r.size_reg <= `SSS_FIFO_BYTES_RST;
      s_r.burst <= `SSS_BURST_RST;
      s_r.code <= `SSS_ERR_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fif.we = push;
  assign fif.waddr = s_r.wp;
  assign fif.wdata = sample_data_in[15:0];
  assign fif.re = pop;
  assign fif.raddr = s_r.rp;

  assign reg_rdata_out = s_r.rdata;
  assign reg_rvalid_out = s_r.rvalid;
  assign acquisition_enable_out = s_r.en;
  assign scan_overlap_error_out = s_r.ovl;
  assign overflow_end_error_out = s_r.ovfe;
  assign error_code_out = s_r.code;
  assign discarded_scans_out = s_r.dropped;
  assign sample_req_out = s_r.req;
  assign sample_ch_out = s_r.ch;
  assign upper_half_capture_out = s_r.upper;
  assign scan_timing_pulse_pin_out = s_r.pin;
  assign fifo_rd_data_out = fif.rdata;
  assign fifo_rd_valid_out = s_r.fvalid;

  property p_overlap;
    @(posedge clk_in) disable iff (!rst_n)
    (tick && s_r.en && s_r.st != SSS_IDLE) |=> (!s_r.en && s_r.ovl && s_r.code == 16'h0b7e);
  endproperty
  a_overlap: assert property (p_overlap) else $error("overlap not reported");

  property p_first_ts;
    @(posedge clk_in) disable iff (!rst_n)
    (s_r.st == SSS_IDLE && tick && s_r.en && !s_r.first) |=> (s_r.ts == $past(tick_cnt));
  endproperty
  a_first_ts: assert property (p_first_ts) else $error("first scan time not latched");

  property p_pin_scan;
    @(posedge clk_in) disable iff (!rst_n)
    (s_r.st == SSS_IDLE && tick && s_r.en) |=> !scan_timing_pulse_pin_out ##1
      (scan_timing_pulse_pin_out || !s_r.en);
  endproperty
  a_pin_scan: assert property (p_pin_scan) else $error("timing pin edges wrong");

  property p_burst;
    @(posedge clk_in) disable iff (!rst_n)
    (s_r.st == SSS_SCAN_END && s_r.burst != 32'h0000_0000 &&
     s_r.scans + 32'h0000_0001 == s_r.burst) |=> !s_r.en;
  endproperty
  a_burst: assert property (p_burst) else $error("burst did not stop stream");

  property p_full_drop;
    @(posedge clk_in) disable iff (!rst_n)
    (s_r.st == SSS_SAMPLE && sample_ack_in && s_r.cnt == s_r.cap && !pop)
      |=> (s_r.cnt == $past(s_r.cnt) && s_r.disc);
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("sample stored into full buffer");

  property p_cap_hold;
    @(posedge clk_in) disable iff (!rst_n)
    ($past(s_r.en) && s_r.en) |-> (s_r.cap == $past(s_r.cap));
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capacity changed mid stream");

  property p_drop_count;
    @(posedge clk_in) disable iff (!rst_n)
    (s_r.st == SSS_SCAN_END && s_r.sdrop) |=> (s_r.dropped == $past(s_r.dropped) + 32'h0000_0001);
  endproperty
  a_drop_count: assert property (p_drop_count) else $error("discarded scan not counted");

  property p_order;
    @(posedge clk_in) disable iff (!rst_n)
    (s_r.st == SSS_SAMPLE_END && s_r.ch != last_ch && s_r.en && !tick)
      |=> (s_r.ch == $past(s_r.ch) + 8'h01 && sample_req_out);
  endproperty
  a_order: assert property (p_order) else $error("channel order broken");
endmodule
`default_nettype wire

//--- tb/sss_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sss_host_model (
  // Clock
  input  wire logic        clk_in,
  // Sample source
  input  wire logic        req_in,
  input  wire logic [7:0]  ch_in,
  input  wire logic [3:0]  delay_in,
  output logic             ack_out,
  output logic [31:0]      data_out,
  output logic             wide_out,
  // Buffer drain
  input  wire logic        drain_in,
  output logic             rd_req_out,
  input  wire logic        rd_valid_in,
  input  wire logic [15:0] rd_data_in
);
  logic [15:0] got[$];
  logic [3:0]  wait_q;
  logic [31:0] val;
  initial begin
    ack_out = 1'b0;
    rd_req_out = 1'b0;
    wait_q = 4'h0;
  end
  // Slot zero never reads all ones, so gap markers stay unambiguous
  assign val = {16'habc0 + {8'h00, ch_in}, 16'h0100 + {8'h00, ch_in}};
  // Inverted word outside an acknowledge, so stale data never looks valid
  assign data_out = ack_out ? val : ~val;
  assign wide_out = ack_out && (ch_in == 8'h01);
  always @(negedge clk_in) begin
    ack_out <= 1'b0;
    if (req_in && !ack_out) begin
      if (wait_q >= delay_in) begin
        ack_out <= 1'b1;
        wait_q <= 4'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
    // Pops every other cycle; the block ignores pops when empty
    rd_req_out <= drain_in && !rd_req_out;
  end
  always @(posedge clk_in) begin
    if (rd_valid_in) begin
      got.push_back(rd_data_in);
    end
  end
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sss_defines.svh"
module testbench;
  logic        clk_in, nrst_in, reg_wr_in, reg_rd_in, reg_rvalid_out;
  logic [15:0] reg_addr_in, fifo_rd_data_out, error_code_out, upper_half_capture_out;
  logic [31:0] reg_wdata_in, reg_rdata_out, scan_period_in, discarded_scans_out;
  logic        acq_enable_set_in, acquisition_enable_out, scan_overlap_error_out;
  logic        overflow_end_error_out, sample_req_out, sample_ack_in, sample_wide_in;
  logic        fifo_rd_req_in, fifo_rd_valid_out, scan_timing_pulse_pin_out;
  logic [7:0]  scan_list_len_in, sample_ch_out;
  logic [31:0] sample_data_in, v, t0;
  logic [3:0]  delay;
  logic        drain, req_q, pin_q;
  int          bad_count, checked, pin_fall, pin_rise, tr, te, tk;
  int          rise_t[$];

  sss_top #(.OVF_TOL_CYC(50)) sss_top_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .acq_enable_set_in(acq_enable_set_in),
    .acq_enable_clr_in(1'b0), .scan_period_in(scan_period_in),
    .scan_list_len_in(scan_list_len_in), .acquisition_enable_out(acquisition_enable_out),
    .scan_overlap_error_out(scan_overlap_error_out),
    .overflow_end_error_out(overflow_end_error_out), .error_code_out(error_code_out),
    .discarded_scans_out(discarded_scans_out), .sample_req_out(sample_req_out),
    .sample_ch_out(sample_ch_out), .sample_ack_in(sample_ack_in),
    .sample_data_in(sample_data_in), .sample_wide_in(sample_wide_in),
    .upper_half_capture_out(upper_half_capture_out),
    .scan_timing_pulse_pin_out(scan_timing_pulse_pin_out), .fifo_rd_req_in(fifo_rd_req_in),
    .fifo_rd_data_out(fifo_rd_data_out), .fifo_rd_valid_out(fifo_rd_valid_out));

  sss_host_model sss_host_model_inst (
    .clk_in(clk_in), .req_in(sample_req_out), .ch_in(sample_ch_out), .delay_in(delay),
    .ack_out(sample_ack_in), .data_out(sample_data_in), .wide_out(sample_wide_in),
    .drain_in(drain), .rd_req_out(fifo_rd_req_in), .rd_valid_in(fifo_rd_valid_out),
    .rd_data_in(fifo_rd_data_out));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Scan starts seen as slot zero requests, and pin edges
  always @(posedge clk_in) begin
    if (sample_req_out && !req_q && sample_ch_out == 8'h00) begin
      rise_t.push_back(int'($time / 10));
    end
    if (pin_q && !scan_timing_pulse_pin_out) begin
      pin_fall++;
    end
    if (!pin_q && scan_timing_pulse_pin_out) begin
      pin_rise++;
    end
    req_q <= sample_req_out;
    pin_q <= scan_timing_pulse_pin_out;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask

  task automatic reg_rd(input logic [15:0] a, output logic [31:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    check("rvalid", {31'h0, reg_rvalid_out}, 32'h1);
    d = reg_rdata_out;
  endtask

  // Start pulse; te is the cycle of the edge that takes it
  task automatic start();
    @(negedge clk_in);
    acq_enable_set_in = 1'b1;
    @(negedge clk_in);
    acq_enable_set_in = 1'b0;
    te = int'(($time - 5) / 10);
  endtask

  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (acquisition_enable_out !== 1'b0 && n < lim) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= lim) begin
      bad_count++;
      $display("ERROR stream_stop expected 0 seen 1");
      final_report();
    end
  endtask

  initial begin
    nrst_in = 1'b0;
    reg_addr_in = 16'h0000;
    reg_wdata_in = 32'h0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    acq_enable_set_in = 1'b0;
    scan_period_in = 32'h14;
    scan_list_len_in = 8'h02;
    delay = 4'h1;
    drain = 1'b0;
    req_q = 1'b0;
    pin_q = 1'b1;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    reg_rd(`SSS_ADDR_FIFO_SIZE, v);
    check("size_rst", v, `SSS_FIFO_BYTES_RST);
    reg_rd(`SSS_ADDR_BURST, v);
    check("burst_rst", v, `SSS_BURST_RST);
    reg_rd(16'h0123, v);
    check("unmapped", v, 32'h0);
    // Reads 200 cycles apart at half rate
    reg_rd(`SSS_ADDR_TICK_CNT, t0);
    repeat (198) @(negedge clk_in);
    reg_rd(`SSS_ADDR_TICK_CNT, v);
    check("tick_rate", v - t0, 32'h64);
    reg_wr(`SSS_ADDR_FIFO_SIZE, 32'h3);
    reg_rd(`SSS_ADDR_FIFO_SIZE, v);
    check("size_npow2", v, 32'h0);
    reg_wr(`SSS_ADDR_FIFO_SIZE, 32'h8);
    reg_rd(`SSS_ADDR_FIFO_SIZE, v);
    check("size_8", v, 32'h8);
    reg_wr(`SSS_ADDR_FIFO_SIZE, 32'h10000);
    reg_rd(`SSS_ADDR_FIFO_SIZE, v);
    check("size_max", v, 32'h8);
    // Burst of 3 scans, 2 slots, room for 4 samples: third scan is dropped
    reg_wr(`SSS_ADDR_BURST, 32'h3);
    reg_rd(`SSS_ADDR_TICK_CNT, t0);
    tr = int'(($time - 5) / 10);
    rise_t.delete();
    pin_fall = 0;
    pin_rise = 0;
    start();
    reg_wr(`SSS_ADDR_FIFO_SIZE, 32'h20);
    wait_idle(400);
    check("scans", rise_t.size(), 32'h3);
    for (int i = 1; i < rise_t.size(); i++) begin
      check("spacing", rise_t[i] - rise_t[i - 1], 32'h14);
    end
    tk = rise_t[0] - te;
    check("first_delay", {31'h0, tk >= 21 && tk <= 25}, 32'h1);
    reg_rd(`SSS_ADDR_FIRST_TS, v);
    tk = int'(v - t0) - (rise_t[0] - 3 - tr) / 2;
    check("first_ts", {31'h0, tk >= -2 && tk <= 2}, 32'h1);
    check("pin_falls", pin_fall, 32'h9);
    check("pin_rises", pin_rise, 32'h9);
    check("discarded", discarded_scans_out, 32'h1);
    check("code_ok", {16'h0, error_code_out}, {16'h0, `SSS_ERR_NONE});
    drain = 1'b1;
    repeat (20) @(negedge clk_in);
    drain = 1'b0;
    check("drained", sss_host_model_inst.got.size(), 32'h4);
    check("padded", sss_host_model_inst.got.size() + discarded_scans_out * scan_list_len_in, 32'h6);
    for (int i = 0; i < 4; i++) begin
      check("sample", {16'h0, sss_host_model_inst.got[i]}, 32'h100 + (i % 2));
    end
    check("upper", {16'h0, upper_half_capture_out}, 32'habc1);
    // Buffer of 2 samples never drained: discard outlasts tolerance
    reg_wr(`SSS_ADDR_FIFO_SIZE, 32'h4);
    reg_wr(`SSS_ADDR_BURST, 32'h0);
    scan_period_in = 32'ha;
    scan_list_len_in = 8'h01;
    delay = 4'h0;
    start();
    wait_idle(600);
    check("ovf_err", {31'h0, overflow_end_error_out}, 32'h1);
    check("ovf_code", {16'h0, error_code_out}, {16'h0, `SSS_ERR_OVF_END});
    // Scan longer than the period
    scan_period_in = 32'h6;
    scan_list_len_in = 8'h02;
    delay = 4'h4;
    start();
    wait_idle(200);
    check("ovl_err", {31'h0, scan_overlap_error_out}, 32'h1);
    check("ovl_code", {16'h0, error_code_out}, {16'h0, `SSS_ERR_OVERLAP});
    check("ovf_clear", {31'h0, overflow_end_error_out}, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
